/* verilog/rxat_table.sv */
// Receive address translation table: indirect register pair and lookup ports
`timescale 1ns/1ps
module rxat_table
    import rxat_pkg::*;
#(
    parameter int NUM_PORTS  = 32,
    parameter int NUM_GROUPS = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // AHB-Lite register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Cell side: Utopia address to internal channel
    input  wire logic [4:0]  fwd_utopia,
    output logic      [5:0]  fwd_chan,
    output logic             fwd_owned,
    output logic             fwd_is_group,
    output logic      [4:0]  fwd_port,
    output logic      [4:0]  fwd_group,
    // Cell side: internal channel to Utopia address
    input  wire logic [5:0]  rev_chan,
    output logic      [4:0]  rev_utopia,
    output logic             rev_active
);
    // Whole package for types, codes and reset values
    import rxat_pkg::*;

    // ------------------------------------------------------------
    // Channel code helpers
    // ------------------------------------------------------------

    // Bypass codes sit below 0x20 and group codes follow from there
    // True when the code names a port or group this instance supports
    function automatic logic chan_ok(input logic [5:0] code);
        if (code < RXAT_GROUP_BASE) begin
            return int'(code) < NUM_PORTS;
        end else if (code < RXAT_NOT_MINE) begin
            return int'(code - RXAT_GROUP_BASE) < NUM_GROUPS;
        end else begin
            return 1'b0;
        end
    endfunction

    // True when the code names an inverse multiplexing group
    function automatic logic chan_is_group(input logic [5:0] code);
        return (code >= RXAT_GROUP_BASE) && (code < RXAT_NOT_MINE);
    endfunction

    // Port number of a bypass code, or group number counted from one
    function automatic logic [4:0] chan_index(input logic [5:0] code);
        if (chan_is_group(code)) begin
            return 5'((code - RXAT_GROUP_BASE) + 6'h01);
        end else begin
            return code[4:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Strobes and read data shared with the bus front end
    rxat_reg_if regs ();

    // Front end turns bus transfers into one-cycle register strobes
    rxat_ahb u_ahb (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .regs      (regs)
    );

    // ------------------------------------------------------------
    // Select register
    // ------------------------------------------------------------
    // Select register and the fields decoded from it
    logic [7:0] select_q;
    logic [7:0] select_d;
    rxat_dir_t  dir;
    logic [4:0] sel_utopia;
    logic [5:0] sel_chan;

    // Whole byte is stored so software reads back what it wrote,
    // the ignored bits included
    always_comb begin
        select_d = select_q;
        if (regs.wr_select) begin
            select_d = regs.wdata;
        end
    end

    // Select flops; reset points at forward entry 0
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            select_q <= RXAT_SELECT_RST;
        end else begin
            select_q <= select_d;
        end
    end

    // Decoded entry selection; the don't-care bits never reach the tables
    // Both fields are decoded at once; the direction bit picks one
    assign dir        = rxat_dir_t'(select_q[RXAT_DIR_BIT]);
    assign sel_utopia = select_q[RXAT_UTOPIA_W-1:0];
    assign sel_chan   = select_q[RXAT_CHAN_W-1:0];

    // ------------------------------------------------------------
    // Table write decode
    // ------------------------------------------------------------
    // Write enables and packed write data of both tables
    logic       fwd_we;
    logic       rev_we;
    logic [5:0] fwd_wdata;
    logic [5:0] rev_wdata;

    // A value write lands only in the entry named by select and direction
    // Forward entries keep any code; reverse writes to channels this
    // size lacks are dropped
    assign fwd_we    = regs.wr_value && (dir == RXAT_DIR_FWD);
    assign rev_we    = regs.wr_value && (dir == RXAT_DIR_REV)
                       && chan_ok(sel_chan);
    assign fwd_wdata = regs.wdata[RXAT_CHAN_W-1:0];
    // Reverse entry packs active flag over the Utopia address
    // Bits 6 and 5 of the write byte are dropped here
    assign rev_wdata = {regs.wdata[RXAT_ACTIVE_BIT],
                        regs.wdata[RXAT_UTOPIA_W-1:0]};

    // ------------------------------------------------------------
    // Table storage
    // ------------------------------------------------------------
    // Bus side and cell side read registers of both tables
    logic [5:0] fwd_bus_rd;
    logic [5:0] fwd_look_rd;
    logic [5:0] rev_bus_rd;
    logic [5:0] rev_look_rd;

    // Utopia address to channel; empty entries read as not ours
    // Bus port follows the select register, cell port the lookup input
    rxat_mem #(
        .DW    (RXAT_CHAN_W),
        .DEPTH (RXAT_FWD_DEPTH),
        .AW    (RXAT_UTOPIA_W),
        .RST   (RXAT_FWD_RST)
    ) u_fwd (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .we      (fwd_we),
        .waddr   (sel_utopia),
        .wdata   (fwd_wdata),
        .raddr_a (sel_utopia),
        .rdata_a (fwd_bus_rd),
        .raddr_b (fwd_utopia),
        .rdata_b (fwd_look_rd)
    );

    // Channel to Utopia address; empty entries read as inactive
    // Codes 0x30 and up fall outside the memory and read as reset
    rxat_mem #(
        .DW    (RXAT_CHAN_W),
        .DEPTH (RXAT_REV_DEPTH),
        .AW    (RXAT_CHAN_W),
        .RST   (RXAT_REV_RST)
    ) u_rev (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .we      (rev_we),
        .waddr   (sel_chan),
        .wdata   (rev_wdata),
        .raddr_a (sel_chan),
        .rdata_a (rev_bus_rd),
        .raddr_b (rev_chan),
        .rdata_b (rev_look_rd)
    );

    // ------------------------------------------------------------
    // Register read back
    // ------------------------------------------------------------

    // Entry contents come straight from the memory read registers; the
    // bus wait state covers the one-cycle read latency
    assign regs.rd_select = select_q;

    // Unsupported reverse channels read zero, like their ignored writes
    always_comb begin
        if (dir == RXAT_DIR_FWD) begin
            regs.rd_value = {2'b00, fwd_bus_rd};
        end else if (chan_ok(sel_chan)) begin
            regs.rd_value = {rev_bus_rd[5], 2'b00, rev_bus_rd[4:0]};
        end else begin
            regs.rd_value = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Cell side lookup outputs
    // ------------------------------------------------------------
    // Forward lookup state
    logic [5:0] fwd_chan_q;
    logic [5:0] fwd_chan_d;
    logic       fwd_owned_q;
    logic       fwd_owned_d;
    logic       fwd_group_q;
    logic       fwd_group_d;
    logic [4:0] fwd_idx_q;
    logic [4:0] fwd_idx_d;

    // Reverse lookup state
    logic [5:0] rev_chan_q;
    logic [5:0] rev_chan_d;
    logic [4:0] rev_utopia_q;
    logic [4:0] rev_utopia_d;
    logic       rev_active_q;
    logic       rev_active_d;

    // Decode the looked-up entry; an unsupported code is treated like 0x30
    // so stale programming can never claim cells for a missing channel
    always_comb begin
        fwd_chan_d   = fwd_look_rd;
        fwd_owned_d  = (fwd_look_rd != RXAT_NOT_MINE)
                       && chan_ok(fwd_look_rd);
        fwd_group_d  = fwd_owned_d && chan_is_group(fwd_look_rd);
        fwd_idx_d    = 5'h00;
        if (fwd_owned_d) begin
            fwd_idx_d = chan_index(fwd_look_rd);
        end
    end

    // Forward output stage; two clocks from address to result
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fwd_chan_q  <= RXAT_FWD_RST;
            fwd_owned_q <= 1'b0;
            fwd_group_q <= 1'b0;
            fwd_idx_q   <= 5'h00;
        end else begin
            fwd_chan_q  <= fwd_chan_d;
            fwd_owned_q <= fwd_owned_d;
            fwd_group_q <= fwd_group_d;
            fwd_idx_q   <= fwd_idx_d;
        end
    end

    // Reverse decode; the channel is delayed one clock so that the
    // support check meets the memory read of that same channel
    always_comb begin
        rev_chan_d   = rev_chan;
        rev_utopia_d = rev_look_rd[4:0];
        rev_active_d = rev_look_rd[5] && chan_ok(rev_chan_q);
    end

    // Reverse output stage; same latency as the forward path
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rev_chan_q   <= 6'h00;
            rev_utopia_q <= 5'h00;
            rev_active_q <= 1'b0;
        end else begin
            rev_chan_q   <= rev_chan_d;
            rev_utopia_q <= rev_utopia_d;
            rev_active_q <= rev_active_d;
        end
    end

    // Port and group numbers read zero unless the entry is of that kind
    assign fwd_chan     = fwd_chan_q;
    assign fwd_owned    = fwd_owned_q;
    assign fwd_is_group = fwd_group_q;
    assign fwd_port     = fwd_group_q ? 5'h00 : fwd_idx_q;
    assign fwd_group    = fwd_group_q ? fwd_idx_q : 5'h00;
    assign rev_utopia   = rev_utopia_q;
    assign rev_active   = rev_active_q;

endmodule

/* verilog/rxat_pkg.sv */
// Package: register map, field layout and reset values of the rx translation table
package rxat_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] RXAT_IDX_SELECT  = 12'h418;
    localparam logic [11:0] RXAT_IDX_VALUE   = 12'h419;
    localparam int          RXAT_ADDR_W      = 14;
    localparam logic [13:0] RXAT_ADR_SELECT  = {RXAT_IDX_SELECT, 2'b00};
    localparam logic [13:0] RXAT_ADR_VALUE   = {RXAT_IDX_VALUE, 2'b00};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RXAT_DIR_BIT      = 7;    // Direction bit of the select register
    localparam int RXAT_ACTIVE_BIT   = 7;    // Active bit of a direction-1 entry
    localparam int RXAT_UTOPIA_W     = 5;    // Utopia address field, bits 4..0
    localparam int RXAT_CHAN_W       = 6;    // Internal channel field, bits 5..0

    // ------------------------------------------------------------
    // Channel codes
    // ------------------------------------------------------------
    localparam logic [5:0] RXAT_GROUP_BASE = 6'h20;  // Code of group 1
    localparam logic [5:0] RXAT_NOT_MINE   = 6'h30;  // Utopia address not owned
    localparam int         RXAT_FWD_DEPTH  = 32;
    localparam int         RXAT_REV_DEPTH  = 48;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RXAT_SELECT_RST = 8'h00;
    localparam logic [5:0] RXAT_FWD_RST    = RXAT_NOT_MINE;
    localparam logic [5:0] RXAT_REV_RST    = 6'h00;   // Inactive, address 0

    // Direction of a table entry
    typedef enum logic {
        RXAT_DIR_FWD = 1'b0,
        RXAT_DIR_REV = 1'b1
    } rxat_dir_t;

    // Bus data phase states, Gray along the read path
    typedef enum logic [1:0] {
        RXAT_BUS_IDLE  = 2'b00,
        RXAT_BUS_WRITE = 2'b10,
        RXAT_BUS_RWAIT = 2'b01,
        RXAT_BUS_RDONE = 2'b11
    } rxat_bus_t;

endpackage

/* verilog/rxat_reg_if.sv */
// Interface: register strobes and read data between bus slave and table core
`timescale 1ns/1ps
interface rxat_reg_if;
    logic       wr_select;   // One-cycle write of the select register
    logic       wr_value;    // One-cycle write of the value register
    logic [7:0] wdata;       // Write byte
    logic [7:0] rd_select;   // Select register contents
    logic [7:0] rd_value;    // Selected entry contents

    modport bus  (output wr_select, output wr_value, output wdata,
                  input rd_select, input rd_value);
    modport core (input wr_select, input wr_value, input wdata,
                  output rd_select, output rd_value);
endinterface

/* verilog/rxat_mem.sv */
// Small table memory: one write port, two registered read ports
`timescale 1ns/1ps
module rxat_mem #(
    parameter int         DW    = 6,
    parameter int         DEPTH = 32,
    parameter int         AW    = 6,
    parameter logic [5:0] RST   = 6'h00
) (
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [DW-1:0] rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_b
);
    logic [DW-1:0] mem_q [DEPTH];

    // Storage and both read registers; reset gives every entry a known value
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= RST[DW-1:0];
            end
            rdata_a <= RST[DW-1:0];
            rdata_b <= RST[DW-1:0];
        end else begin
            if (we && (int'(waddr) < DEPTH)) begin
                mem_q[waddr] <= wdata;
            end
            rdata_a <= (int'(raddr_a) < DEPTH) ? mem_q[raddr_a] : RST[DW-1:0];
            rdata_b <= (int'(raddr_b) < DEPTH) ? mem_q[raddr_b] : RST[DW-1:0];
        end
    end
endmodule

/* verilog/rxat_ahb.sv */
// AHB-Lite slave front end for the translation table register pair
`timescale 1ns/1ps
module rxat_ahb
    import rxat_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    rxat_reg_if.bus          regs
);
    rxat_bus_t               st_q, st_d;
    logic [RXAT_ADDR_W-1:0]  adr_q, adr_d;
    logic                    take;

    // Only NONSEQ or SEQ with the previous transfer done starts a transfer
    assign take = hsel && htrans[1] && hready;

    // Data phase sequencing; reads take one wait state so that a write
    // just before them is already visible in the table read register
    always_comb begin
        st_d  = st_q;
        adr_d = adr_q;
        case (st_q)
            RXAT_BUS_RWAIT: begin
                st_d = RXAT_BUS_RDONE;
            end
            default: begin
                if (take) begin
                    adr_d = haddr[RXAT_ADDR_W-1:0];
                    st_d  = hwrite ? RXAT_BUS_WRITE : RXAT_BUS_RWAIT;
                end else begin
                    st_d = RXAT_BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q  <= RXAT_BUS_IDLE;
            adr_q <= '0;
        end else begin
            st_q  <= st_d;
            adr_q <= adr_d;
        end
    end

    // Write strobes in the data phase; unmapped addresses are ignored
    assign regs.wdata     = hwdata[7:0];
    assign regs.wr_select = (st_q == RXAT_BUS_WRITE) && (adr_q == RXAT_ADR_SELECT);
    assign regs.wr_value  = (st_q == RXAT_BUS_WRITE) && (adr_q == RXAT_ADR_VALUE);

    // Answer: always OKAY, read data from flops, upper bits zero
    assign hresp     = 1'b0;
    assign hreadyout = (st_q != RXAT_BUS_RWAIT);
    always_comb begin
        hrdata = 32'h0000_0000;
        if (st_q == RXAT_BUS_RDONE) begin
            if (adr_q == RXAT_ADR_SELECT) begin
                hrdata = {24'h00_0000, regs.rd_select};
            end else if (adr_q == RXAT_ADR_VALUE) begin
                hrdata = {24'h00_0000, regs.rd_value};
            end
        end
    end

    logic unused_ok;
    assign unused_ok = ^{haddr[31:RXAT_ADDR_W], hsize, hwdata[31:8]};
endmodule

/* testbench/rxat_table_props.sv */
// Checker: bus timing and lookup decode of the rx translation table
`timescale 1ns/1ps
module rxat_table_props #(
    parameter int NUM_PORTS  = 32,
    parameter int NUM_GROUPS = 16
) (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [4:0]  fwd_utopia,
    input wire logic [5:0]  fwd_chan,
    input wire logic        fwd_owned,
    input wire logic        fwd_is_group,
    input wire logic [4:0]  fwd_port,
    input wire logic [4:0]  fwd_group,
    input wire logic [5:0]  rev_chan,
    input wire logic [4:0]  rev_utopia,
    input wire logic        rev_active
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic xfer;
    logic owned_exp;
    assign xfer = hsel && htrans[1] && hready;
    // Smaller family members support fewer codes
    assign owned_exp = (fwd_chan < 6'h20) ? (int'(fwd_chan) < NUM_PORTS)
                     : (fwd_chan < 6'h30 && int'(fwd_chan) - 32 < NUM_GROUPS);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_owned_decode: assert property (fwd_owned == owned_exp)
        else $error("owned flag disagrees with stored code");
    chk_port_number: assert property (fwd_owned && !fwd_is_group
        |-> fwd_port == fwd_chan[4:0])
        else $error("port number differs from code");
    chk_group_number: assert property (fwd_is_group |-> fwd_group == 5'(fwd_chan - 6'h1f))
        else $error("group number not code minus 0x20 plus one");
    chk_group_range: assert property (fwd_is_group == (fwd_owned && fwd_chan[5]))
        else $error("group flag outside 0x20 to 0x2f");
    chk_read_wait: assert property (xfer && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait then ready");
    chk_write_nowait: assert property (xfer && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    chk_rdata_quiet: assert property (!hreadyout |-> hrdata == 32'h0)
        else $error("read data shown during wait");
    chk_rdata_upper: assert property (hrdata[31:8] == 24'h0 && !hresp)
        else $error("upper read bits or error response set");
    chk_lookup_steady: assert property (($stable(fwd_utopia) && $stable(rev_chan)
        && !xfer)[*5] |-> $stable(fwd_chan) && $stable(rev_utopia))
        else $error("lookup moved without cause");
    chk_rev_unsupported: assert property (($stable(rev_chan) && rev_chan >= 6'h30)[*3]
        |-> !rev_active)
        else $error("unsupported channel reported active");
    cover property (xfer && !hwrite);
    cover property (fwd_is_group && fwd_group == 5'h10);
    cover property (rev_active);
endmodule

bind rxat_table rxat_table_props #(.NUM_PORTS(NUM_PORTS), .NUM_GROUPS(NUM_GROUPS)) u_props (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fwd_utopia(fwd_utopia),
    .fwd_chan(fwd_chan), .fwd_owned(fwd_owned), .fwd_is_group(fwd_is_group),
    .fwd_port(fwd_port), .fwd_group(fwd_group), .rev_chan(rev_chan),
    .rev_utopia(rev_utopia), .rev_active(rev_active));

/* testbench/rxat_atm_model.sv */
// Partner model: cell-side device presenting lookup addresses to the table
`timescale 1ns/1ps
module rxat_atm_model (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic [4:0] want_utopia,
    input  wire logic [5:0] want_chan,
    output logic      [4:0] fwd_utopia,
    output logic      [5:0] rev_chan
);
    // Launch lookups just after an edge, as the cell side would
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fwd_utopia <= 5'h00;
            rev_chan   <= 6'h00;
        end else begin
            fwd_utopia <= want_utopia;
            rev_chan   <= want_chan;
        end
    end
endmodule

/* testbench/rxat_table_bench.sv */
// Testbench: register pair, table contents and lookups of the rx translation table
`timescale 1ns/1ps
module rxat_table_bench;
    import rxat_pkg::*;
    logic        clk_sys, nrst, hsel, hwrite, hreadyout, hresp, hready;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  fwd_utopia, fwd_port, fwd_group, rev_utopia, want_utopia;
    logic [5:0]  fwd_chan, rev_chan, want_chan;
    logic        fwd_owned, fwd_is_group, rev_active;
    int          err_total, samples_checked;
    localparam logic [31:0] SEL = {18'h0, RXAT_ADR_SELECT};
    localparam logic [31:0] VAL = {18'h0, RXAT_ADR_VALUE};

    assign hready = hreadyout;
    rxat_table dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fwd_utopia(fwd_utopia),
        .fwd_chan(fwd_chan), .fwd_owned(fwd_owned), .fwd_is_group(fwd_is_group),
        .fwd_port(fwd_port), .fwd_group(fwd_group), .rev_chan(rev_chan),
        .rev_utopia(rev_utopia), .rev_active(rev_active));
    rxat_atm_model u_atm (.clk_sys(clk_sys), .nrst(nrst), .want_utopia(want_utopia),
        .want_chan(want_chan), .fwd_utopia(fwd_utopia), .rev_chan(rev_chan));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic stop_test;
        $display("Counts: %0d compared, %0d mismatched", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait: a stuck hready must not hang the run
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            err_total++;
            stop_test();
        end
    endtask

    // One single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] adr, input logic [7:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= adr;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr_reg(input logic [31:0] adr, input logic [7:0] wd);
        logic [31:0] rd;
        bus(1'b1, adr, wd, rd);
    endtask

    task automatic rd_reg(input logic [31:0] adr, input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, adr, 8'h00, rd);
        check(rd, {24'h0, exp});
    endtask

    // Lookup result is settled two edges after the model launches it
    task automatic look(input logic [4:0] u, input logic [5:0] c);
        want_utopia <= u;
        want_chan   <= c;
        repeat (4) @(posedge clk_sys);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset;
        rd_reg(SEL, 8'h00);
        rd_reg(VAL, 8'h30);
        look(5'h09, 6'h03);
        check(32'({fwd_chan, fwd_owned, rev_active}), 32'({6'h30, 2'b00}));
        $display("test_reset done");
    endtask

    task automatic test_forward;
        logic [4:0] fa[6] = '{5'h00, 5'h1f, 5'h03, 5'h04, 5'h07, 5'h0a};
        logic [5:0] fc[6] = '{6'h00, 6'h1f, 6'h20, 6'h2f, 6'h30, 6'h3f};
        logic       own, grp;
        for (int i = 0; i < 6; i++) begin
            own = fc[i] < 6'h30;
            grp = fc[i] >= 6'h20 && own;
            wr_reg(SEL, {3'b011, fa[i]});
            rd_reg(SEL, {3'b011, fa[i]});
            wr_reg(VAL, {2'b11, fc[i]});
            rd_reg(VAL, {2'b00, fc[i]});
            look(fa[i], 6'h00);
            check(32'(fwd_chan), 32'(fc[i]));
            check(32'({fwd_owned, fwd_is_group}), 32'({own, grp}));
            check(32'(fwd_port), (own && !grp) ? 32'(fc[i][4:0]) : 32'h0);
            check(32'(fwd_group), grp ? 32'(5'(fc[i] - 6'h1f)) : 32'h0);
        end
        wr_reg(SEL, 8'h01);
        rd_reg(VAL, 8'h30);
        $display("test_forward done");
    endtask

    task automatic test_reverse;
        logic [5:0] rc[4] = '{6'h00, 6'h1f, 6'h20, 6'h2f};
        logic [4:0] ra[4] = '{5'h11, 5'h00, 5'h1f, 5'h05};
        logic [3:0] act = 4'b0101;
        for (int i = 0; i < 4; i++) begin
            wr_reg(SEL, {2'b11, rc[i]});
            rd_reg(SEL, {2'b11, rc[i]});
            wr_reg(VAL, {act[i], 2'b11, ra[i]});
            rd_reg(VAL, {act[i], 2'b00, ra[i]});
            look(5'h00, rc[i]);
            check(32'({rev_active, rev_utopia}), 32'({act[i], ra[i]}));
        end
        wr_reg(SEL, 8'hb0);
        wr_reg(VAL, 8'h9f);
        rd_reg(VAL, 8'h00);
        look(5'h00, 6'h30);
        check(32'(rev_active), 32'h0);
        wr_reg(SEL, 8'h1f);
        rd_reg(VAL, 8'h1f);
        $display("test_reverse done");
    endtask

    task automatic test_unmapped;
        wr_reg(VAL + 32'h4, 8'hff);
        rd_reg(VAL + 32'h4, 8'h00);
        rd_reg(SEL, 8'h1f);
        rd_reg(VAL, 8'h1f);
        $display("test_unmapped done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        want_utopia = 5'h00;
        want_chan = 6'h00;
        err_total = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        test_reset();
        test_forward();
        test_reverse();
        test_unmapped();
        stop_test();
    end
endmodule
